// *** hw/pirc_delay_line.sv ***
// Tapped delay line for the pad input, one tap per clock cycle.
// Assumes the input is already synchronised to i_clk.
`timescale 1ns/1ps
module pirc_delay_line
	import pirc_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_din,
	input  wire logic [PIRC_DLY_W-1:0] i_tap,
	output logic                       o_dout
);

	logic [PIRC_DLY_TAPS-1:0] taps;

	assign taps[0] = i_din;

	// ****************************************
	// Delay stages
	// ****************************************
	genvar g;
	generate
		for (g = 1; g < PIRC_DLY_TAPS; g++) begin : g_stage
			// Each stage owns its flop, so no variable is shared between processes.
			logic stage_q;
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					stage_q <= 1'b0;
				end else begin
					stage_q <= taps[g-1];
				end
			end
			assign taps[g] = stage_q;
		end
	endgenerate

	// Tap zero is the undelayed input, so a zero selection adds no latency.
	assign o_dout = taps[i_tap];

endmodule

// *** hw/pirc_pkg.sv ***
// Shared constants and carriers for the pin input register cell.
// Assumes one 125 MHz clock and a 32-bit AHB-Lite slave port.
package pirc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] PIRC_OFS_CTRL   = 32'h0000_0000;
	localparam logic [31:0] PIRC_OFS_STATUS = 32'h0000_0004;
	localparam logic [31:0] PIRC_RD_ZERO    = 32'h0000_0000;

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [1:0] PIRC_MODE_BYPASS = 2'h0;
	localparam logic [1:0] PIRC_MODE_SDR    = 2'h1;
	localparam logic [1:0] PIRC_MODE_DDR    = 2'h2;
	localparam logic [1:0] PIRC_EDGE_LEFT   = 2'h0;
	localparam logic [1:0] PIRC_EDGE_TOP    = 2'h1;
	localparam logic [1:0] PIRC_EDGE_BOTTOM = 2'h2;
	localparam logic [1:0] PIRC_EDGE_RIGHT  = 2'h3;

	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int          PIRC_DLY_W    = 5;
	localparam int          PIRC_DLY_TAPS = 32;
	localparam int          PIRC_DIV_W    = 4;
	localparam int          PIRC_NSYNC    = 4;
	localparam logic [4:0]  PIRC_TAP_NONE = 5'h00;
	localparam logic [3:0]  PIRC_CNT_ZERO = 4'h0;
	localparam logic [3:0]  PIRC_CNT_ONE  = 4'h1;
	localparam logic [3:0]  PIRC_SYNC_RST = 4'h0;
	localparam logic        PIRC_TRI_INIT = 1'b1;
	localparam logic [1:0]  PIRC_HTRANS_NONSEQ_BIT = 2'h2;

	// Control word; bit 31 at the top, mode at the bottom.
	typedef struct packed {
		logic        lock;
		logic [13:0] rsv;
		logic [3:0]  sclk_div;
		logic        init_val;
		logic        out_ddr;
		logic        dyn_dly_en;
		logic [4:0]  fixed_dly;
		logic        fixed_dly_en;
		logic [1:0]  edge_sel;
		logic [1:0]  mode;
	} pirc_cfg_s;

	localparam pirc_cfg_s PIRC_CFG_RST = '0;

	// Status word, read only.
	typedef struct packed {
		logic [19:0] rsv;
		logic        lock;
		logic [4:0]  tap;
		logic        tri_en;
		logic        pad_out;
		logic        sclk;
		logic        bypass;
		logic        fall_cap;
		logic        rise_cap;
	} pirc_stat_s;

endpackage

// *** hw/pirc_top.sv ***
// Pin input register cell: bypass, delay, SDR/DDR capture, output and tri-state registers.
// Assumes an AHB-Lite master on i_clk and an asynchronous pad and strobe domain.
//
// Functional notes
// - Every cell has a delay line and capture registers in front of the core.
// - A bypass path hands the synchronised pad straight out as data and as clock.
// - A fixed delay tap can be chosen and placed in front of the capture registers.
// - Bottom-edge cells also take a five-bit run-time delay selection.
// - Single-rate mode captures the pad once per system clock rising edge.
// - Double-rate mode captures on both system clock edges into two streams; right-edge cells use the read strobe edges instead.
// - Only right-edge cells use the memory strobe logic for capture.
// - Right-edge cells swap capture edges according to a polarity control.
// - The cell drives output data and a separate tri-state enable to the pad.
// - One system clock paces the input, output and tri-state registers, except in right-edge DDR where the read and write strobes do.
// - A local set/reset forces the capture and output registers to the configured initial value and the tri-state register high.
// - DDR rising sample goes to the first output, falling to the second; SDR uses the second.
// - A clock enable gates every capture, output and tri-state update; local set/reset acts regardless of it.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module pirc_top
	import pirc_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	input  wire logic                  i_hsel,
	input  wire logic [31:0]           i_haddr,
	input  wire logic [1:0]            i_htrans,
	input  wire logic                  i_hwrite,
	input  wire logic [2:0]            i_hsize,
	input  wire logic [31:0]           i_hwdata,
	input  wire logic                  i_hready,
	output logic                       o_hreadyout,
	output logic                       o_hresp,
	output logic [31:0]                o_hrdata,
	input  wire logic                  i_pad_in,
	input  wire logic                  i_strobe_read_clk_shifted,
	input  wire logic                  i_strobe_write_clk_shifted,
	input  wire logic                  i_capture_polarity_ctrl,
	input  wire logic [PIRC_DLY_W-1:0] i_dynamic_delay_sel,
	input  wire logic                  i_ce,
	input  wire logic                  i_lsr,
	input  wire logic                  i_core_d0,
	input  wire logic                  i_core_d1,
	input  wire logic                  i_core_tristate,
	output logic                       o_bypass_data_out,
	output logic                       o_bypass_clock_out,
	output logic                       o_rise_capture_out,
	output logic                       o_fall_capture_out,
	output logic                       o_pad_output,
	output logic                       o_pad_output_tristate
);

	// ****************************************
	// Declarations
	// ****************************************
	pirc_cfg_s                cfg_q;
	pirc_cfg_s                cfg_wr;
	pirc_stat_s               stat;
	logic [31:0]              addr_q;
	logic                     wr_pend_q;
	logic                     rd_pend_q;
	logic [31:0]              hrdata_q;
	logic [PIRC_NSYNC-1:0]    s1_q;
	logic [PIRC_NSYNC-1:0]    s2_q;
	logic [1:0]               s3_q;
	logic [PIRC_DIV_W-1:0]    cnt_q;
	logic                     sclk_q;
	logic                     rise_q;
	logic                     fall_q;
	logic                     pad_q;
	logic                     tri_q;
	logic                     bus_take;
	logic                     ctrl_wr;
	logic [31:0]              rd_mux;
	logic                     pad_s;
	logic                     rd_strobe;
	logic                     wr_strobe;
	logic                     pol_s;
	logic                     sclk_toggle;
	logic                     sclk_rise;
	logic                     sclk_fall;
	logic                     is_right;
	logic                     is_bottom;
	logic                     right_ddr;
	logic                     rd_rise;
	logic                     rd_fall;
	logic                     wr_rise;
	logic                     wr_fall;
	logic                     cap_rise_ev;
	logic                     cap_fall_ev;
	logic                     out_rise_ev;
	logic                     out_fall_ev;
	logic                     mode_sdr;
	logic                     mode_ddr;
	logic [PIRC_DLY_W-1:0]    active_tap;
	logic                     tap_data;

	localparam pirc_cfg_s PIRC_CFG_MASK_RSV = '{rsv: '1, default: '0};

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	// Reads take one wait state so that a write in the previous data phase is
	// already committed when the read data is sampled.
	assign bus_take    = i_hsel & i_hready & (|(i_htrans & PIRC_HTRANS_NONSEQ_BIT));
	assign o_hreadyout = !rd_pend_q;
	assign o_hresp     = 1'b0;
	assign o_hrdata    = hrdata_q;
	assign ctrl_wr     = wr_pend_q & (addr_q == PIRC_OFS_CTRL) & !cfg_q.lock;
	assign cfg_wr      = pirc_cfg_s'(i_hwdata) & ~PIRC_CFG_MASK_RSV;
	assign rd_mux      = (addr_q == PIRC_OFS_CTRL)   ? 32'(cfg_q) :
	                     (addr_q == PIRC_OFS_STATUS) ? 32'(stat)  : PIRC_RD_ZERO;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			addr_q    <= PIRC_RD_ZERO;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
		end else begin
			wr_pend_q <= bus_take & i_hwrite;
			rd_pend_q <= bus_take & !i_hwrite;
			if (bus_take) begin
				addr_q <= i_haddr;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			hrdata_q <= PIRC_RD_ZERO;
		end else if (rd_pend_q) begin
			hrdata_q <= rd_mux;
		end
	end

	// Once lock is set, mode and delay stay fixed until reset.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cfg_q <= PIRC_CFG_RST;
		end else if (ctrl_wr) begin
			cfg_q <= cfg_wr;
		end
	end

	assign stat = '{rsv: '0, lock: cfg_q.lock, tap: active_tap, tri_en: tri_q,
	                pad_out: pad_q, sclk: sclk_q, bypass: s2_q[0],
	                fall_cap: fall_q, rise_cap: rise_q};

	// ****************************************
	// Input synchronisers
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s1_q <= PIRC_SYNC_RST;
			s2_q <= PIRC_SYNC_RST;
			s3_q <= 2'h0;
		end else begin
			s1_q <= {i_capture_polarity_ctrl, i_strobe_write_clk_shifted,
			         i_strobe_read_clk_shifted, i_pad_in};
			s2_q <= s1_q;
			s3_q <= s2_q[2:1];
		end
	end

	assign pad_s     = s2_q[0];
	assign rd_strobe = s2_q[1];
	assign wr_strobe = s2_q[2];
	assign pol_s     = s2_q[3];

	// The bypass path skips the delay line and the capture registers.
	assign o_bypass_data_out  = pad_s;
	assign o_bypass_clock_out = pad_s;

	// ****************************************
	// System clock divider
	// ****************************************
	// The system clock is a divided phase of i_clk; its edges are enable pulses.
	assign sclk_toggle = (cnt_q >= cfg_q.sclk_div);
	assign sclk_rise   = sclk_toggle & !sclk_q;
	assign sclk_fall   = sclk_toggle & sclk_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_q  <= PIRC_CNT_ZERO;
			sclk_q <= 1'b0;
		end else if (sclk_toggle) begin
			cnt_q  <= PIRC_CNT_ZERO;
			sclk_q <= !sclk_q;
		end else begin
			cnt_q  <= cnt_q + PIRC_CNT_ONE;
		end
	end

	// ****************************************
	// Delay selection
	// ****************************************
	assign is_bottom  = (cfg_q.edge_sel == PIRC_EDGE_BOTTOM);
	assign is_right   = (cfg_q.edge_sel == PIRC_EDGE_RIGHT);
	assign active_tap = (is_bottom & cfg_q.dyn_dly_en) ? i_dynamic_delay_sel :
	                    cfg_q.fixed_dly_en             ? cfg_q.fixed_dly     :
	                    PIRC_TAP_NONE;

	pirc_delay_line u_delay (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_din   (pad_s),
		.i_tap   (active_tap),
		.o_dout  (tap_data)
	);

	// ****************************************
	// Capture and output event selection
	// ****************************************
	// Strobe edges are seen two cycles late; the shifted strobes absorb that skew.
	assign mode_sdr    = (cfg_q.mode == PIRC_MODE_SDR);
	assign mode_ddr    = (cfg_q.mode == PIRC_MODE_DDR);
	assign right_ddr   = is_right & mode_ddr;
	assign rd_rise     = rd_strobe & !s3_q[0];
	assign rd_fall     = !rd_strobe & s3_q[0];
	assign wr_rise     = wr_strobe & !s3_q[1];
	assign wr_fall     = !wr_strobe & s3_q[1];
	assign cap_rise_ev = right_ddr ? (pol_s ? rd_fall : rd_rise) : sclk_rise;
	assign cap_fall_ev = right_ddr ? (pol_s ? rd_rise : rd_fall) : sclk_fall;
	assign out_rise_ev = right_ddr ? wr_rise : sclk_rise;
	assign out_fall_ev = right_ddr ? wr_fall : sclk_fall;

	// ****************************************
	// Input capture registers
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else if (i_lsr) begin
			rise_q <= cfg_q.init_val;
			fall_q <= cfg_q.init_val;
		end else if (i_ce) begin
			if (mode_ddr && cap_rise_ev) begin
				rise_q <= tap_data;
			end
			if ((mode_ddr && cap_fall_ev) || (mode_sdr && cap_rise_ev)) begin
				fall_q <= tap_data;
			end
		end
	end

	assign o_rise_capture_out = rise_q;
	assign o_fall_capture_out = fall_q;

	// ****************************************
	// Output and tri-state registers
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pad_q <= 1'b0;
			tri_q <= PIRC_TRI_INIT;
		end else if (i_lsr) begin
			pad_q <= cfg_q.init_val;
			tri_q <= PIRC_TRI_INIT;
		end else if (i_ce) begin
			if (out_rise_ev) begin
				pad_q <= i_core_d0;
				tri_q <= i_core_tristate;
			end else if (out_fall_ev && cfg_q.out_ddr) begin
				pad_q <= i_core_d1;
			end
		end
	end

	assign o_pad_output          = pad_q;
	assign o_pad_output_tristate = tri_q;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_sdr_take;
		mode_sdr && i_ce && !i_lsr && cap_rise_ev;
	endsequence

	sequence s_ddr_fall_take;
		mode_ddr && i_ce && !i_lsr && cap_fall_ev;
	endsequence

	property p_bypass_path;
		$past(i_rst_n, 2) |-> (o_bypass_data_out == $past(i_pad_in, 2));
	endproperty
	a_bypass_path: assert property (p_bypass_path)
		else $error("Bypass data does not follow the pad two cycles later.");

	property p_fixed_tap;
		(!is_bottom && cfg_q.fixed_dly_en) |-> (active_tap == cfg_q.fixed_dly);
	endproperty
	a_fixed_tap: assert property (p_fixed_tap)
		else $error("Fixed delay tap not applied.");

	property p_dyn_bottom_only;
		(!is_bottom && !cfg_q.fixed_dly_en) |-> (active_tap == PIRC_TAP_NONE);
	endproperty
	a_dyn_bottom_only: assert property (p_dyn_bottom_only)
		else $error("Dynamic delay used off the bottom edge.");

	property p_sdr_capture;
		s_sdr_take |=> (fall_q == $past(tap_data)) && $stable(rise_q);
	endproperty
	a_sdr_capture: assert property (p_sdr_capture)
		else $error("Single-rate capture wrong.");

	property p_ddr_fall;
		s_ddr_fall_take ##0 !cap_rise_ev |=> (fall_q == $past(tap_data)) && $stable(rise_q);
	endproperty
	a_ddr_fall: assert property (p_ddr_fall)
		else $error("Falling sample not on the second output.");

	property p_sclk_edges;
		!right_ddr |-> (cap_rise_ev == sclk_rise) && (cap_fall_ev == sclk_fall);
	endproperty
	a_sclk_edges: assert property (p_sclk_edges)
		else $error("Strobe capture used outside right-edge DDR.");

	property p_polarity;
		(right_ddr && pol_s && rd_fall) |-> cap_rise_ev && !cap_fall_ev;
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("Polarity control did not swap capture edges.");

	property p_lsr_init;
		i_lsr |=> (rise_q == $past(cfg_q.init_val)) && (fall_q == $past(cfg_q.init_val))
		          && tri_q;
	endproperty
	a_lsr_init: assert property (p_lsr_init)
		else $error("Local set/reset did not load the initial state.");

	property p_ce_hold;
		(!i_ce && !i_lsr) |=> $stable(rise_q) && $stable(fall_q) && $stable(tri_q);
	endproperty
	a_ce_hold: assert property (p_ce_hold)
		else $error("Register changed with clock enable low.");

	property p_tristate;
		(i_ce && !i_lsr && out_rise_ev) |=> (tri_q == $past(i_core_tristate))
		                                    && (pad_q == $past(i_core_d0));
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("Output or tri-state register not loaded on the rising edge.");

	property p_lock_static;
		cfg_q.lock |=> $stable(cfg_q) [*2];
	endproperty
	a_lock_static: assert property (p_lock_static)
		else $error("Configuration changed while locked.");

endmodule

// *** testbench/pin_input_register_cell_test.sv ***
// Self-checking bench for the pin input register cell, driven over AHB-Lite.
// Assumes the package constants and the designer's timing figures for the cell.
`timescale 1ns/1ps
module pin_input_register_cell_test;
	import pirc_pkg::*;
	logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0]  htrans;
	logic        pad, rd_clk, wr_clk, pol, pol_req, run, slow, ce, lsr, d0, d1, tri_in;
	logic [4:0]  dsel;
	logic        byp_d, byp_c, rise, fall, pad_o, pad_t;
	pirc_cfg_s   cf;
	int          miscompares;
	int          n_tests;

	always #4 clk = ~clk;

	pirc_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_pad_in(pad), .i_strobe_read_clk_shifted(rd_clk),
		.i_strobe_write_clk_shifted(wr_clk), .i_capture_polarity_ctrl(pol),
		.i_dynamic_delay_sel(dsel), .i_ce(ce), .i_lsr(lsr), .i_core_d0(d0),
		.i_core_d1(d1), .i_core_tristate(tri_in), .o_bypass_data_out(byp_d),
		.o_bypass_clock_out(byp_c), .o_rise_capture_out(rise), .o_fall_capture_out(fall),
		.o_pad_output(pad_o), .o_pad_output_tristate(pad_t));

	pirc_core_model far (.i_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_slow(slow),
		.i_pol(pol_req), .o_rd_clk(rd_clk), .o_wr_clk(wr_clk), .o_pol(pol));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Caller stands just after a rising edge; the bus is always held until hready.
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] w);
		hsel   <= 1'b1;
		htrans <= PIRC_HTRANS_NONSEQ_BIT;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] w);
		xfer(1'b1, a, w);
	endtask

	task automatic rd(input logic [31:0] a);
		xfer(1'b0, a, 32'h0);
	endtask

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// Watchdog
	// ****************************************
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		report_and_stop;
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		clk = 0; rst_n = 0; hsel = 0; haddr = '0; htrans = 2'h0; hwrite = 0; hwdata = '0;
		pad = 0; pol_req = 0; run = 0; slow = 0; dsel = 5'h00; ce = 1; lsr = 0;
		d0 = 0; d1 = 0; tri_in = 1; cf = '0; miscompares = 0; n_tests = 0;
		cyc(2);
		rst_n <= 1'b1;
		check("tri_rst", {31'h0, pad_t}, 32'h1);
		rd(PIRC_OFS_CTRL);
		check("ctrl_rst", rdv, 32'h0);
		wr(PIRC_OFS_CTRL, 32'h7FFF_FFFF);
		rd(PIRC_OFS_CTRL);
		check("ctrl_rw", rdv, 32'h0001_FFFF);
		rd(32'h0000_0010);
		check("unmapped", rdv, PIRC_RD_ZERO);
		wr(PIRC_OFS_CTRL, cf);
		pad <= 1'b1; cyc(4);
		check("byp_d", {31'h0, byp_d}, 32'h1);
		check("byp_c", {31'h0, byp_c}, 32'h1);
		pad <= 1'b0; cyc(4);
		check("byp_d0", {31'h0, byp_d}, 32'h0);
		cf.mode = PIRC_MODE_SDR; wr(PIRC_OFS_CTRL, cf);
		pad <= 1'b1; cyc(8);
		check("sdr1", {31'h0, fall}, 32'h1);
		pad <= 1'b0; cyc(8);
		check("sdr0", {31'h0, fall}, 32'h0);
		d0 <= 1'b1; tri_in <= 1'b0; cyc(6);
		check("pad_o", {31'h0, pad_o}, 32'h1);
		check("pad_t", {31'h0, pad_t}, 32'h0);
		d0 <= 1'b0; tri_in <= 1'b1; ce <= 1'b0; pad <= 1'b1; cyc(8);
		check("ce_hold", {31'h0, fall}, 32'h0);
		ce <= 1'b1; cyc(8);
		check("ce_go", {31'h0, fall}, 32'h1);
		ce <= 1'b0; lsr <= 1'b1; cyc(2);
		check("lsr0", {31'h0, fall}, 32'h0);
		check("lsr_tri", {31'h0, pad_t}, 32'h1);
		lsr <= 1'b0; ce <= 1'b1; pad <= 1'b0;
		cf.init_val = 1'b1; wr(PIRC_OFS_CTRL, cf); cyc(8);
		lsr <= 1'b1; cyc(2);
		check("lsr1", {31'h0, fall}, 32'h1);
		lsr <= 1'b0; cf.init_val = 1'b0;
		cf.mode = PIRC_MODE_DDR; cf.sclk_div = 4'hF; cf.out_ddr = 1'b1; d1 <= 1'b1;
		wr(PIRC_OFS_CTRL, cf);
		pad <= 1'b1; cyc(80);
		check("ddr_r1", {31'h0, rise}, 32'h1);
		check("ddr_f1", {31'h0, fall}, 32'h1);
		rd(PIRC_OFS_STATUS);
		check("out_ddr", {31'h0, rdv[4]}, {31'h0, ~rdv[3]});
		pad <= 1'b0; cyc(80);
		check("ddr_r0", {31'h0, rise}, 32'h0);
		cf.mode = PIRC_MODE_SDR; cf.sclk_div = 4'h0;
		cf.fixed_dly_en = 1'b1; cf.fixed_dly = 5'h14; wr(PIRC_OFS_CTRL, cf); cyc(30);
		pad <= 1'b1; cyc(12);
		check("fix_early", {31'h0, fall}, 32'h0);
		cyc(18);
		check("fix_late", {31'h0, fall}, 32'h1);
		pad <= 1'b0; dsel <= 5'h14;
		cf.fixed_dly_en = 1'b0; cf.fixed_dly = 5'h00; cf.dyn_dly_en = 1'b1;
		cf.edge_sel = PIRC_EDGE_BOTTOM; wr(PIRC_OFS_CTRL, cf); cyc(30);
		rd(PIRC_OFS_STATUS);
		check("tap", {27'h0, rdv[10:6]}, 32'h14);
		pad <= 1'b1; cyc(12);
		check("dyn_early", {31'h0, fall}, 32'h0);
		cyc(18);
		check("dyn_late", {31'h0, fall}, 32'h1);
		pad <= 1'b0; cyc(30);
		cf.edge_sel = PIRC_EDGE_LEFT; wr(PIRC_OFS_CTRL, cf); cyc(4);
		pad <= 1'b1; cyc(8);
		check("dyn_left", {31'h0, fall}, 32'h1);
		pad <= 1'b0; cyc(30);
		cf.edge_sel = PIRC_EDGE_RIGHT; cf.dyn_dly_en = 1'b0; cf.mode = PIRC_MODE_DDR;
		wr(PIRC_OFS_CTRL, cf);
		pad <= 1'b1; cyc(30);
		check("strobe_idle", {31'h0, rise}, 32'h0);
		run <= 1'b1; cyc(40);
		check("strobe_r", {31'h0, rise}, 32'h1);
		check("strobe_f", {31'h0, fall}, 32'h1);
		pad <= 1'b0; pol_req <= 1'b1; slow <= 1'b1; cyc(80);
		check("pol_r", {31'h0, rise}, 32'h0);
		check("pol_f", {31'h0, fall}, 32'h0);
		run <= 1'b0;
		cf = '0; cf.mode = PIRC_MODE_SDR; cf.lock = 1'b1; wr(PIRC_OFS_CTRL, cf);
		wr(PIRC_OFS_CTRL, 32'h0);
		rd(PIRC_OFS_CTRL);
		check("locked", rdv, 32'h8000_0001);
		report_and_stop;
	end
endmodule

// *** testbench/pirc_core_model.sv ***
// Far-side model: memory strobe clocks and polarity as seen by a right-edge cell.
// Assumes the bench paces it with i_clk and gates the strobes per burst.
`timescale 1ns/1ps
module pirc_core_model (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_run,
	input  wire logic i_slow,
	input  wire logic i_pol,
	output logic      o_rd_clk,
	output logic      o_wr_clk,
	output logic      o_pol
);
	// ****************************************
	// Strobe generator
	// ****************************************
	// Slow mode halves the strobe rate, so the cell is also seen with a lazy memory.
	logic [2:0] cnt_q;
	logic       div_q;
	wire  [2:0] shifted = cnt_q - 3'h2;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_run) begin
			cnt_q <= 3'h0;
			div_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
			if (!i_slow || div_q) begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
		o_pol <= i_pol;
	end

	// Both strobes stand low between bursts; the write strobe lags a quarter period.
	assign o_rd_clk = i_run & cnt_q[2];
	assign o_wr_clk = i_run & shifted[2];
endmodule
